// >>> bfap_checker.sv
// assertion checker for the boot, flash access and protection block
`timescale 1ns/1ps
`include "bfap_defines.vh"
module bfap_checker (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // observed ports
   input wire [1:0] boot_source,
   input wire boot_pins_released,
   input wire [3:0] wait_cycles,
   input wire instruction_bus_req,
   input wire instruction_bus_grant,
   input wire data_bus_port_req,
   input wire [31:0] data_bus_port_addr,
   input wire data_bus_port_grant,
   input wire [31:0] mem_addr,
   input wire dma_rd_req,
   input wire [31:0] dma_rd_addr,
   input wire dma_rd_blocked,
   input wire op_req,
   input wire [31:0] op_addr,
   input wire op_allowed,
   input wire op_denied
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_pins_hold: assert property (boot_pins_released && $past(boot_pins_released) |->
      $stable(boot_source)) else $error("boot source moved");
   a_src_legal: assert property (boot_source != 2'h3) else $error("bad source");
   a_alias_sys: assert property (data_bus_port_req && boot_pins_released &&
      boot_source == `BFAP_SRC_LOADER && data_bus_port_addr < `BFAP_ALIAS_TOP |=>
      mem_addr == (`BFAP_SYSMEM_BASE | ($past(data_bus_port_addr) & 32'h0000_0FFF)))
      else $error("alias address wrong");
   a_data_wins: assert property (data_bus_port_req && instruction_bus_req |=>
      data_bus_port_grant && !instruction_bus_grant) else $error("data bus lost");
   a_wait_sat: assert property (wait_cycles <= `BFAP_WAIT_MAX) else $error("wait");
   a_dma_open: assert property (dma_rd_req && dma_rd_addr >= `BFAP_CODE_TOP |=>
      !dma_rd_blocked) else $error("dma blocked outside code");
   a_info_low: assert property (op_req && op_addr >= `BFAP_INFO_BASE &&
      op_addr < `BFAP_INFO_BASE + 32'h0000_0400 |=> op_denied && !op_allowed)
      else $error("low info block writable");
   a_op_one: assert property (op_req |=> op_allowed ^ op_denied) else $error("op");
   c_data: cover property (data_bus_port_grant);
   c_deny: cover property (op_denied);
   c_dma: cover property (dma_rd_blocked);
endmodule
bind bfap_top bfap_checker chk_u (.hclk(hclk), .hresetn(hresetn), .boot_source(boot_source),
   .boot_pins_released(boot_pins_released), .wait_cycles(wait_cycles),
   .instruction_bus_req(instruction_bus_req), .instruction_bus_grant(instruction_bus_grant),
   .data_bus_port_req(data_bus_port_req), .data_bus_port_addr(data_bus_port_addr),
   .data_bus_port_grant(data_bus_port_grant), .mem_addr(mem_addr), .dma_rd_req(dma_rd_req),
   .dma_rd_addr(dma_rd_addr), .dma_rd_blocked(dma_rd_blocked), .op_req(op_req),
   .op_addr(op_addr), .op_allowed(op_allowed), .op_denied(op_denied));

// >>> bfap_cpu_model.sv
// processor bus master model: vector fetch after boot
`timescale 1ns/1ps
module bfap_cpu_model (
   // clock and command
   input wire hclk,
   input wire go,
   input wire ig,
   // buses
   output logic ireq,
   output logic [31:0] iaddr,
   output logic dreq,
   output logic [31:0] daddr
);
   // ----------------------------------------
   // stack word on data bus, vector on instruction bus
   // ----------------------------------------
   logic [1:0] st;
   initial begin
      st = 2'h0;
      ireq = 1'b0;
      dreq = 1'b0;
      iaddr = 32'h0000_0000;
      daddr = 32'h0000_0000;
   end
   always @(posedge hclk) begin
      if (go && st == 2'h0) begin
         dreq <= 1'b1;
         daddr <= 32'h0000_0000;
         ireq <= 1'b1;
         iaddr <= 32'h0000_0004;
         st <= 2'h1;
      end else if (st == 2'h1) begin
         dreq <= 1'b0;
         daddr <= ~daddr;
         st <= 2'h2;
      end else if (st == 2'h2 && ig) begin
         ireq <= 1'b0;
         iaddr <= ~iaddr;
         st <= 2'h3;
      end
   end
endmodule

// >>> bfap_defines.vh
// constants for the boot, flash access and protection block
`ifndef BFAP_DEFINES_VH
`define BFAP_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BFAP_CACHE_OFS 12'h000
`define BFAP_STAT_OFS 12'h004
`define BFAP_WEN_OFS 12'h008
`define BFAP_ID_OFS 12'h00C
// ----------------------------------------
// cache control fields and reset
// ----------------------------------------
`define BFAP_CACHE_RST 32'h0300_0000
`define BFAP_CACHE_MASK 32'h0300_013F
`define BFAP_CACHE_HI 25
`define BFAP_CACHE_LO 24
`define BFAP_HSA_BIT 8
`define BFAP_PREF_HI 5
`define BFAP_PREF_LO 4
`define BFAP_WAIT_HI 3
`define BFAP_WAIT_LO 0
`define BFAP_FIELD_ON 2'h3
`define BFAP_WAIT_MAX 4'h4
// ----------------------------------------
// boot capture and boot sources
// ----------------------------------------
`define BFAP_BOOT_EDGE 3'h4
`define BFAP_SRC_FLASH 2'h0
`define BFAP_SRC_LOADER 2'h1
`define BFAP_SRC_SRAM 2'h2
// ----------------------------------------
// address map
// ----------------------------------------
`define BFAP_ALIAS_TOP 32'h0002_0000
`define BFAP_FLASH_BASE 32'h0800_0000
`define BFAP_FLASH_TOP 32'h0805_0000
`define BFAP_SYSMEM_BASE 32'h1FFF_E000
`define BFAP_SYSMEM_TOP 32'h1FFF_F000
`define BFAP_INFO_BASE 32'h1FFF_F000
`define BFAP_INFO_TOP 32'h1FFF_F800
`define BFAP_SRAM_BASE 32'h2000_0000
`define BFAP_CODE_TOP 32'h2000_0000
`define BFAP_BLK_LIMIT 32'h0002_0000
// ----------------------------------------
// memory target codes
// ----------------------------------------
`define BFAP_TGT_NONE 2'h0
`define BFAP_TGT_FLASH 2'h1
`define BFAP_TGT_SYSMEM 2'h2
`define BFAP_TGT_SRAM 2'h3
// ----------------------------------------
// identity (value is arbitrary)
// ----------------------------------------
`define BFAP_ID_VALUE 32'h0000_0A5C
`endif

// >>> bfap_top.v
// boot select, flash access control and code memory protection
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "bfap_defines.vh"
// What this block does
// [R1] boot pins captured on fourth edge after reset
// [R2] primary low flash, then loader, else sram
// [R3] pins ignored after capture, released flag set
// [R4] vector words at zero reach boot memory
// [R5] region at zero aliased to chosen memory
// [R6] cache field bits 25:24, resets enabled
// [R7] software sets assist bit above 96 MHz
// [R8] prefetch field bits 5:4
// [R9] wait field bits 3:0, codes 0..4
// [R10] configuration bits take effect after reset
// [R11] security level from four protection bits
// [R12] read protect blocks dma code reads
// [R13] eight info blocks of 256 bytes
// [R14] info blocks 0-3 never writable
// [R15] info blocks 4-7 have own lock
// [R16] software never erases locked info blocks
// [R17] block 7 upper part usable when unlocked
// [R18] 4K system memory in fixed window
// [R19] 32 bits per 4K, top covers beyond 128K
// [R20] bit n guards block at base plus n*4K
// [R21] zero bit forbids erase and program
// [R22] data bus wins flash over instruction bus
// [R23] prefetch holds two 128-bit slots
// [R24] reserved cache bits read reset value
module bfap_top (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg [31:0] hrdata,
   output reg hresp,
   // boot pins and stored configuration
   input wire boot_select_primary,
   input wire boot_select_secondary,
   input wire read_protect,
   input wire ram_boot_block,
   input wire debug_port_block,
   input wire sysmem_boot_block,
   input wire [31:0] main_wen,
   input wire info4_lock,
   input wire info5_lock,
   input wire info6_lock,
   input wire info7_lock,
   output reg [1:0] boot_source,
   output reg boot_pins_released,
   output reg [1:0] security_level,
   output reg debug_blocked,
   // cache controls
   output reg [1:0] cache_on,
   output reg high_speed_assist,
   output reg [1:0] prefetch_on,
   output reg [3:0] wait_cycles,
   // processor buses
   input wire instruction_bus_req,
   input wire [31:0] instruction_bus_addr,
   input wire data_bus_port_req,
   input wire [31:0] data_bus_port_addr,
   output reg instruction_bus_grant,
   output reg data_bus_port_grant,
   output reg [31:0] mem_addr,
   output reg [1:0] mem_target,
   output reg instr_hit,
   output reg [31:0] instr_hit_word,
   // flash line return for prefetch
   input wire line_valid,
   input wire [31:0] line_addr,
   input wire [127:0] line_data,
   // dma read check
   input wire dma_rd_req,
   input wire [31:0] dma_rd_addr,
   output reg dma_rd_blocked,
   // flash erase and program check
   input wire op_req,
   input wire [31:0] op_addr,
   output reg op_allowed,
   output reg op_denied
);

// ----------------------------------------
// boot capture and configuration latch
// ----------------------------------------
reg [2:0] edge_cnt_reg;
reg rp_reg;
reg rbb_reg;
reg dpb_reg;
reg sbb_reg;
reg [31:0] wen_reg;
reg [7:4] lock_reg;
wire capture = (edge_cnt_reg == (`BFAP_BOOT_EDGE - 3'h1));

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      edge_cnt_reg <= 3'h0;
      boot_source <= `BFAP_SRC_FLASH;
      boot_pins_released <= 1'b0;
      rp_reg <= 1'b0;
      rbb_reg <= 1'b0;
      dpb_reg <= 1'b0;
      sbb_reg <= 1'b0;
      wen_reg <= 32'h0000_0000;
      lock_reg <= 4'h0;
   end else begin
      if (edge_cnt_reg != `BFAP_BOOT_EDGE)
         edge_cnt_reg <= edge_cnt_reg + 3'h1;
      if (capture) begin // see [R1]
         boot_pins_released <= 1'b1; // see [R3]
         if (!boot_select_primary)
            boot_source <= `BFAP_SRC_FLASH; // see [R2]
         else if (!boot_select_secondary)
            boot_source <= `BFAP_SRC_LOADER;
         else
            boot_source <= `BFAP_SRC_SRAM;
         // stored settings only change at reset, see [R10]
         rp_reg <= read_protect;
         rbb_reg <= ram_boot_block;
         dpb_reg <= debug_port_block;
         sbb_reg <= sysmem_boot_block;
         wen_reg <= main_wen;
         lock_reg <= {info7_lock, info6_lock, info5_lock, info4_lock};
      end
   end
end

// ----------------------------------------
// security level
// ----------------------------------------
reg [1:0] level_next;
always @* begin
   level_next = 2'h0; // see [R11]
   if (rp_reg && rbb_reg) begin
      if (dpb_reg && sbb_reg)
         level_next = 2'h3;
      else if (dpb_reg)
         level_next = 2'h2;
      else
         level_next = 2'h1;
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      security_level <= 2'h0;
      debug_blocked <= 1'b0;
   end else begin
      security_level <= level_next;
      debug_blocked <= dpb_reg || (level_next == 2'h1);
   end
end

// ----------------------------------------
// ahb-lite register slave
// ----------------------------------------
reg [31:0] cache_reg;
reg wr_pend_reg;
reg [11:0] wr_ofs_reg;
wire take = hsel && hready && htrans[1];

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      cache_reg <= `BFAP_CACHE_RST;
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
   end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= take && hwrite;
      if (take)
         wr_ofs_reg <= haddr[11:0];
      if (wr_pend_reg && (wr_ofs_reg == `BFAP_CACHE_OFS))
         // reserved bits keep reset value, see [R24]
         cache_reg <= (hwdata & `BFAP_CACHE_MASK) |
            (`BFAP_CACHE_RST & ~`BFAP_CACHE_MASK); // see [R6]
      if (take && !hwrite) begin
         case (haddr[11:0])
            `BFAP_CACHE_OFS: hrdata <= cache_reg;
            `BFAP_STAT_OFS: hrdata <= {20'h0_0000, lock_reg,
               sbb_reg, dpb_reg, rbb_reg, rp_reg,
               security_level, boot_source};
            `BFAP_WEN_OFS: hrdata <= wen_reg;
            `BFAP_ID_OFS: hrdata <= `BFAP_ID_VALUE;
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      cache_on <= 2'h3;
      high_speed_assist <= 1'b0;
      prefetch_on <= 2'h0;
      wait_cycles <= 4'h0;
   end else begin
      cache_on <= cache_reg[`BFAP_CACHE_HI:`BFAP_CACHE_LO]; // see [R6]
      high_speed_assist <= cache_reg[`BFAP_HSA_BIT];
      prefetch_on <= cache_reg[`BFAP_PREF_HI:`BFAP_PREF_LO]; // see [R8]
      // reserved wait codes saturate at the slowest setting, see [R9]
      if (cache_reg[`BFAP_WAIT_HI:`BFAP_WAIT_LO] > `BFAP_WAIT_MAX)
         wait_cycles <= `BFAP_WAIT_MAX;
      else
         wait_cycles <= cache_reg[`BFAP_WAIT_HI:`BFAP_WAIT_LO];
   end
end

// ----------------------------------------
// bus arbitration and boot alias
// ----------------------------------------
reg [31:0] sel_addr;
reg [31:0] phys_addr;
reg [1:0] tgt_next;
always @* begin
   // data bus first, see [R22]
   sel_addr = data_bus_port_req ? data_bus_port_addr : instruction_bus_addr;
   phys_addr = sel_addr;
   if (sel_addr < `BFAP_ALIAS_TOP) begin // see [R5]
      // vector fetches at zero and four land here too, see [R4]
      case (boot_source)
         `BFAP_SRC_FLASH: phys_addr = `BFAP_FLASH_BASE + sel_addr;
         `BFAP_SRC_LOADER: phys_addr = `BFAP_SYSMEM_BASE + {20'h0_0000, sel_addr[11:0]};
         default: phys_addr = `BFAP_SRAM_BASE + sel_addr;
      endcase
   end
   if (phys_addr >= `BFAP_FLASH_BASE && phys_addr < `BFAP_FLASH_TOP)
      tgt_next = `BFAP_TGT_FLASH;
   else if (phys_addr >= `BFAP_SYSMEM_BASE && phys_addr < `BFAP_INFO_TOP)
      tgt_next = `BFAP_TGT_SYSMEM; // see [R18]
   else if (phys_addr >= `BFAP_SRAM_BASE)
      tgt_next = `BFAP_TGT_SRAM;
   else
      tgt_next = `BFAP_TGT_NONE;
end

// ----------------------------------------
// prefetch line slots
// ----------------------------------------
reg [127:0] slot_data [0:1];
reg [27:0] slot_tag [0:1];
reg [1:0] slot_vld;
reg fill_ptr_reg;
reg hit_next;
reg [31:0] hit_word_next;
wire [31:0] ib_phys = phys_addr;

genvar gi;
generate
   for (gi = 0; gi < 2; gi = gi + 1) begin : g_slot
      always @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            slot_data[gi] <= 128'h0;
            slot_tag[gi] <= 28'h000_0000;
            slot_vld[gi] <= 1'b0;
         end else if (prefetch_on != `BFAP_FIELD_ON) begin
            slot_vld[gi] <= 1'b0;
         end else if (line_valid && (fill_ptr_reg == gi)) begin // see [R23]
            slot_data[gi] <= line_data;
            slot_tag[gi] <= line_addr[31:4];
            slot_vld[gi] <= 1'b1;
         end
      end
   end
endgenerate

always @* begin
   hit_next = 1'b0;
   hit_word_next = 32'h0000_0000;
   if (instruction_bus_req && !data_bus_port_req) begin
      if (slot_vld[0] && slot_tag[0] == ib_phys[31:4]) begin
         hit_next = 1'b1;
         hit_word_next = slot_data[0][ib_phys[3:2]*32 +: 32];
      end else if (slot_vld[1] && slot_tag[1] == ib_phys[31:4]) begin
         hit_next = 1'b1;
         hit_word_next = slot_data[1][ib_phys[3:2]*32 +: 32];
      end
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      fill_ptr_reg <= 1'b0;
      instruction_bus_grant <= 1'b0;
      data_bus_port_grant <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_target <= `BFAP_TGT_NONE;
      instr_hit <= 1'b0;
      instr_hit_word <= 32'h0000_0000;
   end else begin
      if (line_valid && prefetch_on == `BFAP_FIELD_ON)
         fill_ptr_reg <= ~fill_ptr_reg;
      data_bus_port_grant <= data_bus_port_req; // see [R22]
      instruction_bus_grant <= instruction_bus_req && !data_bus_port_req;
      mem_addr <= phys_addr;
      mem_target <= (instruction_bus_req || data_bus_port_req) ? tgt_next : `BFAP_TGT_NONE;
      instr_hit <= hit_next;
      instr_hit_word <= hit_word_next;
   end
end

// ----------------------------------------
// dma and erase/program protection
// ----------------------------------------
reg allow_next;
wire [31:0] fofs = op_addr - `BFAP_FLASH_BASE;
wire [2:0] info_blk = op_addr[10:8]; // see [R13]

always @* begin
   allow_next = 1'b0;
   if (op_addr >= `BFAP_FLASH_BASE && op_addr < `BFAP_FLASH_TOP) begin
      if (fofs >= `BFAP_BLK_LIMIT)
         allow_next = wen_reg[31]; // see [R19]
      else
         allow_next = wen_reg[fofs[16:12]]; // see [R20] [R21]
   end else if (op_addr >= `BFAP_INFO_BASE && op_addr < `BFAP_INFO_TOP) begin
      if (!info_blk[2])
         allow_next = 1'b0; // see [R14]
      else
         // block 7 otp area follows its lock, see [R15] [R17]
         allow_next = !lock_reg[{1'b1, info_blk[1:0]}];
   end
end

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      op_allowed <= 1'b0;
      op_denied <= 1'b0;
      dma_rd_blocked <= 1'b0;
   end else begin
      op_allowed <= op_req && allow_next;
      op_denied <= op_req && !allow_next;
      dma_rd_blocked <= dma_rd_req && rp_reg && (dma_rd_addr < `BFAP_CODE_TOP); // see [R12]
   end
end

endmodule

// >>> tb_top.sv
// self-checking bench for the boot, flash access and protection block
`timescale 1ns/1ps
`include "bfap_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic hclk, hresetn, hwrite, boot_select_primary, boot_select_secondary, go, dma_rd_req;
   logic read_protect, ram_boot_block, debug_port_block, sysmem_boot_block, op_req;
   logic info4_lock, info5_lock, info6_lock, info7_lock, line_valid;
   logic [31:0] haddr, hwdata, main_wen, dma_rd_addr, op_addr, rd, line_addr;
   logic [127:0] line_data;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire hready, hreadyout, hresp, boot_pins_released, high_speed_assist, dma_rd_blocked;
   wire instruction_bus_req, data_bus_port_req, instruction_bus_grant, data_bus_port_grant;
   wire op_allowed, op_denied, debug_blocked, instr_hit;
   wire [31:0] hrdata, instruction_bus_addr, data_bus_port_addr, mem_addr, instr_hit_word;
   wire [1:0] boot_source, security_level, cache_on, prefetch_on, mem_target;
   wire [3:0] wait_cycles;
   int bad_count, n_compared, i;
   logic [11:0] ra[7] = '{12'h000, 12'h000, 12'h000, 12'h010, 12'h004, 12'h008, 12'h00C};
   logic [31:0] rw[7] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0134, 32'hFFFF_FFFF,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
   // status row: level 1 from the first boot's settings, info5 locked, flash boot
   logic [31:0] rx[7] = '{32'h0300_013F, 32'h0000_0000, 32'h0000_0134, 32'h0000_0000,
      32'h0000_02B4, 32'h8000_0001, `BFAP_ID_VALUE};
   logic [31:0] oa[8] = '{32'h0800_0000, 32'h0800_1000, 32'h0801_F000, 32'h0802_0000,
      32'h1FFF_F200, 32'h1FFF_F500, 32'h1FFF_F720, 32'h2000_0000};
   logic ok[8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   assign hready = hreadyout;
   bfap_top dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hrdata, .hresp, .boot_select_primary, .boot_select_secondary,
      .read_protect, .ram_boot_block, .debug_port_block, .sysmem_boot_block, .main_wen,
      .info4_lock, .info5_lock, .info6_lock, .info7_lock, .boot_source, .boot_pins_released,
      .security_level, .debug_blocked, .cache_on, .high_speed_assist, .prefetch_on,
      .wait_cycles, .instruction_bus_req, .instruction_bus_addr, .data_bus_port_req,
      .data_bus_port_addr, .instruction_bus_grant, .data_bus_port_grant, .mem_addr,
      .mem_target, .instr_hit, .instr_hit_word, .line_valid,
      .line_addr, .line_data, .dma_rd_req, .dma_rd_addr,
      .dma_rd_blocked, .op_req, .op_addr, .op_allowed, .op_denied);
   bfap_cpu_model cpu_u (.hclk, .go, .ig(instruction_bus_grant), .ireq(instruction_bus_req),
      .iaddr(instruction_bus_addr), .dreq(data_bus_port_req), .daddr(data_bus_port_addr));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task final_report;
      if (bad_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task do_reset(input logic p, input logic s, input logic [1:0] src);
      boot_select_primary <= p;
      boot_select_secondary <= s;
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      #1 `CHK(boot_pins_released, 1'b0)
      @(posedge hclk);
      #1 `CHK(boot_pins_released, 1'b1)
      `CHK(boot_source, src)
      @(posedge hclk);
   endtask
   // ----------------------------------------
   // clock, watchdog and sequence
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   initial begin
      #1_000_000;
      bad_count++;
      final_report;
   end
   initial begin
      hresetn = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      go = 1'b0;
      dma_rd_req = 1'b0;
      op_req = 1'b0;
      dma_rd_addr = 32'h0000_0000;
      op_addr = 32'h0000_0000;
      main_wen = 32'h8000_0001;
      line_valid = 1'b0;
      line_addr = 32'h0000_0000;
      line_data = 128'h0;
      // level 1 settings: read and ram boot blocked, debug port bit clear but blocked by level 1
      {read_protect, ram_boot_block, debug_port_block, sysmem_boot_block} = 4'hD;
      {info4_lock, info5_lock, info6_lock, info7_lock} = 4'h4;
      do_reset(1'b0, 1'b1, `BFAP_SRC_FLASH);
      bus(1'b0, 32'h0000_0000, 32'h0000_0000);
      `CHK(rd, `BFAP_CACHE_RST)
      for (i = 0; i < 7; i++) begin
         bus(1'b1, {20'h0_0000, ra[i]}, rw[i]);
         bus(1'b0, {20'h0_0000, ra[i]}, 32'h0000_0000);
         `CHK(rd, rx[i])
         `CHK(hresp, 1'b0)
      end
      `CHK(wait_cycles, 4'h4)
      `CHK(prefetch_on, 2'h3)
      `CHK(high_speed_assist, 1'b1)
      `CHK(cache_on, 2'h0)
      `CHK(debug_blocked, 1'b1)
      {read_protect, ram_boot_block, debug_port_block, sysmem_boot_block} <= 4'h0;
      do_reset(1'b1, 1'b1, `BFAP_SRC_SRAM);
      @(posedge hclk);
      `CHK(security_level, 2'h0)
      `CHK(debug_blocked, 1'b0)
      {read_protect, ram_boot_block, debug_port_block, sysmem_boot_block} <= 4'hF;
      do_reset(1'b1, 1'b0, `BFAP_SRC_LOADER);
      // prefetch on, then one line of boot memory into a slot
      bus(1'b1, 32'h0000_0000, 32'h0300_0030);
      @(posedge hclk);
      line_valid <= 1'b1;
      line_addr <= `BFAP_SYSMEM_BASE;
      line_data <= 128'h4444_4444_3333_3333_2222_2222_1111_1111;
      @(posedge hclk);
      line_valid <= 1'b0;
      `CHK(security_level, 2'h3)
      `CHK(debug_blocked, 1'b1)
      // stored settings move after capture, the latched copies must not
      {read_protect, ram_boot_block, debug_port_block, sysmem_boot_block} <= 4'h0;
      boot_select_primary <= 1'b0;
      main_wen <= 32'h0000_0000;
      go <= 1'b1;
      i = 0;
      while (data_bus_port_grant !== 1'b1 && i < 20) begin
         @(posedge hclk);
         #1 i++;
      end
      `CHK(instruction_bus_grant, 1'b0)
      `CHK(instr_hit, 1'b0)
      `CHK(mem_addr, `BFAP_SYSMEM_BASE)
      `CHK(mem_target, `BFAP_TGT_SYSMEM)
      i = 0;
      while (instruction_bus_grant !== 1'b1 && i < 20) begin
         @(posedge hclk);
         #1 i++;
      end
      `CHK(mem_addr, `BFAP_SYSMEM_BASE + 32'h0000_0004)
      `CHK(instr_hit, 1'b1)
      `CHK(instr_hit_word, 32'h2222_2222)
      `CHK(boot_source, `BFAP_SRC_LOADER)
      // one request per address, including locked info block 5, which must be denied
      for (i = 0; i < 8; i++) begin
         op_req <= 1'b1;
         op_addr <= oa[i];
         dma_rd_req <= 1'b1;
         dma_rd_addr <= oa[i];
         @(posedge hclk);
         #1 `CHK(op_allowed, ok[i])
         `CHK(dma_rd_blocked, oa[i] < `BFAP_CODE_TOP)
      end
      final_report;
   end
endmodule
